// ==== shared/rsp_pkg.sv ====
// constants, register map and helper functions of the multi-drop serial slave port
// assumes a 100 MHz hclk and a 32-bit ahb-lite register bus with one word per register
package rsp_pkg;
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned MS_PER_SEC   = 1000;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_PER_SEC;

   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_DELAY    = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_RXDATA   = 8'h0c;
   localparam logic [7:0] ADDR_TXDATA   = 8'h10;

   localparam int CTRL_ID_LSB    = 0;
   localparam int CTRL_PROTO_BIT = 8;
   localparam int CTRL_RATE_LSB  = 9;
   localparam int CTRL_FRAME_LSB = 12;

   localparam logic [7:0] ID_RESET      = 8'h01;
   localparam logic [7:0] ID_MIN        = 8'h01;
   localparam logic [7:0] ID_MAX        = 8'hfa;
   localparam logic [2:0] RATE_RESET    = 3'h3;
   localparam logic [2:0] RATE_MAX      = 3'h5;
   localparam logic [6:0] DELAY_RESET   = 7'h05;
   localparam logic [6:0] DELAY_MIN     = 7'h02;
   localparam logic [6:0] DELAY_MAX     = 7'h64;

   localparam int ST_RXVALID  = 0;
   localparam int ST_TXFULL   = 1;
   localparam int ST_ARMED    = 2;
   localparam int ST_DRIVING  = 3;
   localparam int ST_PARERR   = 4;
   localparam int ST_FRMERR   = 5;
   localparam int ST_OVERRUN  = 6;
   localparam int ST_CODEERR  = 7;
   localparam int ST_CNT_LSB  = 8;

   localparam int FIFO_DEPTH  = 4;
   localparam int DATA_BITS   = 8;

   typedef enum logic [1:0] {
      RSP_FR_N1,
      RSP_FR_N2,
      RSP_FR_E1,
      RSP_FR_O1
   } rsp_frame_t;

   // cycles per bit for each rate code; codes above five fall back to the slowest rate
   function automatic logic [16:0] rsp_bit_div(input logic [2:0] code);
      unique case (code)
         3'h0:    rsp_bit_div = 17'(CLK_HZ / 1200);
         3'h1:    rsp_bit_div = 17'(CLK_HZ / 2400);
         3'h2:    rsp_bit_div = 17'(CLK_HZ / 4800);
         3'h3:    rsp_bit_div = 17'(CLK_HZ / 9600);
         3'h4:    rsp_bit_div = 17'(CLK_HZ / 19200);
         3'h5:    rsp_bit_div = 17'(CLK_HZ / 38400);
         default: rsp_bit_div = 17'(CLK_HZ / 1200);
      endcase
   endfunction

   // parity bit to send or expect for a byte under a framing choice
   function automatic logic rsp_parity(input logic [7:0] d, input rsp_frame_t fr);
      rsp_parity = (fr == RSP_FR_O1) ? ~(^d) : (^d);
   endfunction
endpackage

// ==== core/rsp_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
module rsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic [$clog2(DEPTH+1)-1:0]    count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             push;
   logic             pop;

   assign in_ready  = (count != ($clog2(DEPTH+1))'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            count <= count + ($clog2(DEPTH+1))'(1);
         end else if (pop && !push) begin
            count <= count - ($clog2(DEPTH+1))'(1);
         end
      end
   end

   always_ff @(posedge hclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ==== core/rsp_port.sv ====
// half-duplex multi-drop serial slave port with an ahb-lite register file
// assumes hclk at 100 MHz, a line transceiver driven by tx_line/tx_drive, and rx_line synchronous to hclk
module rsp_port #(
   parameter int unsigned CYC_PER_MS = rsp_pkg::CYC_PER_MS
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   input  wire logic          rx_line,
   output logic               tx_line,
   output logic               tx_drive
);
   import rsp_pkg::*;

   typedef enum {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rsp_rx_t;
   typedef enum {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} rsp_tx_t;

   // configuration
   logic [7:0]  station_id;
   logic        proto_ascii;
   logic [2:0]  rate_code;
   rsp_frame_t  frame;
   logic [6:0]  delay_ms;

   // bus
   logic        ap_valid;
   logic        dp_write;
   logic [7:0]  dp_addr;
   logic        rd_pop;
   logic        wr_ctrl;
   logic        wr_delay;
   logic        wr_status;
   logic        wr_tx;
   logic [31:0] next_rdata;

   // receiver
   rsp_rx_t     rx_st;
   logic        rx_q;
   logic [16:0] rx_cnt;
   logic [2:0]  rx_bit;
   logic [7:0]  rx_shift;
   logic        rx_perr;
   logic        rx_done;
   logic        rx_ferr;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [7:0]  fifo_out_data;
   logic [2:0]  fifo_count;
   logic [3:0]  err_flags;

   // transmitter and reply timing
   rsp_tx_t     tx_st;
   logic [16:0] tx_cnt;
   logic [2:0]  tx_bit;
   logic        tx_stop2;
   logic [7:0]  tx_hold;
   logic        tx_full;
   logic [7:0]  tx_shift;
   logic        tx_take;
   logic        tx_end;
   logic        armed;
   logic        dly_done;
   logic [16:0] ms_cnt;
   logic [6:0]  ms_elapsed;
   logic [16:0] bit_div;

   assign bit_div = rsp_bit_div(rate_code);

   // ---------------- ahb-lite slave, zero wait states ----------------
   assign ap_valid  = hsel && htrans[1] && hready;
   assign rd_pop    = ap_valid && !hwrite && (haddr[7:0] == ADDR_RXDATA) && fifo_out_valid;
   assign wr_ctrl   = dp_write && (dp_addr == ADDR_CTRL);
   assign wr_delay  = dp_write && (dp_addr == ADDR_DELAY);
   assign wr_status = dp_write && (dp_addr == ADDR_STATUS);
   assign wr_tx     = dp_write && (dp_addr == ADDR_TXDATA);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write  <= 1'b0;
         dp_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_write  <= ap_valid && hwrite && (haddr[31:8] == 24'h00_0000);
         dp_addr   <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (ap_valid && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000) begin
         unique case (haddr[7:0])
            ADDR_CTRL: begin
               next_rdata[CTRL_ID_LSB +: 8]    = station_id;
               next_rdata[CTRL_PROTO_BIT]      = proto_ascii;
               next_rdata[CTRL_RATE_LSB +: 3]  = rate_code;
               next_rdata[CTRL_FRAME_LSB +: 2] = frame;
            end
            ADDR_DELAY:  next_rdata[6:0] = delay_ms;
            ADDR_STATUS: begin
               next_rdata[ST_RXVALID]       = fifo_out_valid;
               next_rdata[ST_TXFULL]        = tx_full;
               next_rdata[ST_ARMED]         = armed;
               next_rdata[ST_DRIVING]       = tx_drive;
               next_rdata[ST_CODEERR:ST_PARERR] = err_flags;
               next_rdata[ST_CNT_LSB +: 3]  = fifo_count;
            end
            ADDR_RXDATA: next_rdata[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
            default:     next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // out-of-range values are dropped field by field so a bad write cannot leave a bogus setting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         station_id  <= ID_RESET;
         proto_ascii <= 1'b0;
         rate_code   <= RATE_RESET;
         frame       <= RSP_FR_N1;
         delay_ms    <= DELAY_RESET;
      end else begin
         if (wr_ctrl) begin
            if (hwdata[CTRL_ID_LSB +: 8] >= ID_MIN && hwdata[CTRL_ID_LSB +: 8] <= ID_MAX) begin
               station_id <= hwdata[CTRL_ID_LSB +: 8];
            end
            if (hwdata[CTRL_RATE_LSB +: 3] <= RATE_MAX) begin
               rate_code <= hwdata[CTRL_RATE_LSB +: 3];
            end
            proto_ascii <= hwdata[CTRL_PROTO_BIT];
            frame       <= rsp_frame_t'(hwdata[CTRL_FRAME_LSB +: 2]);
         end
         if (wr_delay && hwdata[6:0] >= DELAY_MIN && hwdata[6:0] <= DELAY_MAX) begin
            delay_ms <= hwdata[6:0];
         end
      end
   end

   // ---------------- receiver ----------------
   // deaf while driving: the transceiver echoes our own reply back on rx_line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_q     <= 1'b1;
         rx_st    <= R_IDLE;
         rx_cnt   <= 17'h0_0000;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
         rx_perr  <= 1'b0;
         rx_ferr  <= 1'b0;
         rx_done  <= 1'b0;
      end else begin
         rx_q    <= rx_line;
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
         if (rx_st != R_IDLE && rx_cnt != 17'h0_0000) begin
            rx_cnt <= rx_cnt - 17'h0_0001;
         end else begin
            unique case (rx_st)
               R_IDLE: begin
                  if (!rx_q && !tx_drive) begin
                     rx_st  <= R_START;
                     rx_cnt <= bit_div >> 1;
                  end
               end
               R_START: begin
                  rx_st  <= rx_q ? R_IDLE : R_DATA;
                  rx_cnt <= bit_div - 17'h0_0001;
                  rx_bit <= 3'h0;
               end
               R_DATA: begin
                  rx_shift <= {rx_q, rx_shift[7:1]};
                  rx_bit   <= rx_bit + 3'h1;
                  rx_cnt   <= bit_div - 17'h0_0001;
                  if (rx_bit == 3'(DATA_BITS - 1)) begin
                     rx_st <= (frame == RSP_FR_E1 || frame == RSP_FR_O1) ? R_PAR : R_STOP;
                  end
               end
               R_PAR: begin
                  rx_perr <= (rx_q != rsp_parity(rx_shift, frame));
                  rx_st   <= R_STOP;
                  rx_cnt  <= bit_div - 17'h0_0001;
               end
               R_STOP: begin
                  // one stop bit is checked; a second one just looks like idle line
                  rx_ferr <= !rx_q;
                  rx_done <= rx_q;
                  rx_st   <= R_IDLE;
                  if (!(frame == RSP_FR_E1 || frame == RSP_FR_O1)) begin
                     rx_perr <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   rsp_fifo #(
      .WIDTH (DATA_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (rx_done),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_shift),
      .out_valid (fifo_out_valid),
      .out_ready (rd_pop),
      .out_data  (fifo_out_data),
      .count     (fifo_count)
   );

   // sticky errors, write one to clear; a new event in the clearing cycle wins
   logic [3:0] err_set;
   assign err_set = {rx_done && proto_ascii && rx_shift[7],
                     rx_done && !fifo_in_ready,
                     rx_ferr,
                     rx_done && rx_perr};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_flags <= 4'h0;
      end else begin
         err_flags <= (err_flags & ~(wr_status ? hwdata[ST_CODEERR:ST_PARERR] : 4'h0)) | err_set;
      end
   end

   // ---------------- reply timing ----------------
   // armed only by a received character, so the port never opens a transfer itself
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed      <= 1'b0;
         dly_done   <= 1'b0;
         ms_cnt     <= 17'h0_0000;
         ms_elapsed <= 7'h00;
      end else if (rx_done) begin
         armed      <= 1'b1;
         dly_done   <= 1'b0;
         ms_cnt     <= 17'h0_0000;
         ms_elapsed <= 7'h00;
      end else if (tx_end && !tx_full) begin
         armed <= 1'b0;
      end else if (armed && !dly_done) begin
         if (ms_elapsed >= delay_ms) begin
            dly_done <= 1'b1;
         end else if (ms_cnt == 17'(CYC_PER_MS - 1)) begin
            ms_cnt     <= 17'h0_0000;
            ms_elapsed <= ms_elapsed + 7'h01;
         end else begin
            ms_cnt <= ms_cnt + 17'h0_0001;
         end
      end
   end

   // ---------------- transmitter ----------------
   assign tx_take = tx_full && armed && dly_done && rx_st == R_IDLE &&
                    (tx_st == T_IDLE || tx_end);
   assign tx_end  = (tx_st == T_STOP) && (tx_cnt == 17'h0_0000) && !tx_stop2;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_hold <= 8'h00;
         tx_full <= 1'b0;
      end else if (wr_tx && !tx_full) begin
         tx_hold <= hwdata[7:0];
         tx_full <= 1'b1;
      end else if (tx_take) begin
         tx_full <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st    <= T_IDLE;
         tx_cnt   <= 17'h0_0000;
         tx_bit   <= 3'h0;
         tx_stop2 <= 1'b0;
         tx_shift <= 8'h00;
         tx_line  <= 1'b1;
         tx_drive <= 1'b0;
      end else if (tx_take) begin
         tx_st    <= T_START;
         tx_shift <= tx_hold;
         tx_cnt   <= bit_div - 17'h0_0001;
         tx_line  <= 1'b0;
         tx_drive <= 1'b1;
      end else if (tx_st != T_IDLE && tx_cnt != 17'h0_0000) begin
         tx_cnt <= tx_cnt - 17'h0_0001;
      end else begin
         unique case (tx_st)
            T_IDLE: begin
               tx_line  <= 1'b1;
               tx_drive <= 1'b0;
            end
            T_START: begin
               tx_st   <= T_DATA;
               tx_bit  <= 3'h0;
               tx_cnt  <= bit_div - 17'h0_0001;
               tx_line <= tx_shift[0];
            end
            T_DATA: begin
               tx_cnt <= bit_div - 17'h0_0001;
               tx_bit <= tx_bit + 3'h1;
               if (tx_bit == 3'(DATA_BITS - 1)) begin
                  if (frame == RSP_FR_E1 || frame == RSP_FR_O1) begin
                     tx_st   <= T_PAR;
                     tx_line <= rsp_parity(tx_shift, frame);
                  end else begin
                     tx_st    <= T_STOP;
                     tx_line  <= 1'b1;
                     tx_stop2 <= (frame == RSP_FR_N2);
                  end
               end else begin
                  tx_line <= tx_shift[3'(tx_bit + 3'h1)];
               end
            end
            T_PAR: begin
               tx_st    <= T_STOP;
               tx_cnt   <= bit_div - 17'h0_0001;
               tx_line  <= 1'b1;
               tx_stop2 <= 1'b0;
            end
            T_STOP: begin
               if (tx_stop2) begin
                  tx_stop2 <= 1'b0;
                  tx_cnt   <= bit_div - 17'h0_0001;
               end else begin
                  tx_st    <= T_IDLE;
                  tx_drive <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule

// ==== dv/rsp_port_asserts.sv ====
// pin-level checker for the serial slave port, bound to its top module
// assumes one clock domain; frame length bound uses the fastest rate code
module rsp_port_asserts #(
   parameter int unsigned CYC_PER_MS = 100000
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rx_line,
   input wire logic        tx_line,
   input wire logic        tx_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_CHAR = 26040;
   logic [31:0] quiet_cnt;
   logic [31:0] drive_cnt;
   logic        seen_req;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // saturates so a long idle spell never wraps back under the delay bound
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) quiet_cnt <= '0;
      else if (!rx_line) quiet_cnt <= '0;
      else if (quiet_cnt != '1) quiet_cnt <= quiet_cnt + 32'h1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) drive_cnt <= '0;
      else if (tx_drive) drive_cnt <= drive_cnt + 32'h1;
      else drive_cnt <= '0;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) seen_req <= 1'b0;
      else if (!rx_line) seen_req <= 1'b1;
   end

   sequence rd_req;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence rd_hole;
      rd_req ##0 (haddr > 32'h10);
   endsequence
   sequence start_bit;
      !tx_line [*2];
   endsequence

   chk_ready_always: assert property (hreadyout) else $error("bus stalled");
   chk_resp_okay: assert property (!hresp) else $error("error response");
   chk_line_idle: assert property (!tx_drive |-> tx_line) else $error("line low while released");
   chk_start_low: assert property ($rose(tx_drive) |-> start_bit) else $error("no start bit");
   chk_half_duplex: assert property (tx_drive |-> rx_line) else $error("driving over master");
   chk_slave_only: assert property ($rose(tx_drive) |-> seen_req) else $error("unsolicited reply");
   chk_reply_delay: assert property ($rose(tx_drive) |-> quiet_cnt >= 2 * CYC_PER_MS)
      else $error("reply too early");
   chk_frame_len: assert property ($fell(tx_drive) |-> drive_cnt >= MIN_CHAR)
      else $error("char too short");
   chk_upper_zero: assert property (rd_req |=> hrdata[31:16] == 16'h0) else $error("upper bits set");
   chk_hole_zero: assert property (rd_hole |=> hrdata == 32'h0) else $error("hole reads nonzero");
endmodule

bind rsp_port rsp_port_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .rx_line(rx_line), .tx_line(tx_line), .tx_drive(tx_drive));

// ==== dv/rsp_master.sv ====
// master controller model: sends even-parity chars and captures replies
// assumes the port runs at the same bit period DIV (in hclk cycles)
module rsp_master #(
   parameter int DIV = 2604
) (
   input  wire logic hclk,
   output logic      line_out,
   input  wire logic tx_line,
   input  wire logic tx_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_byte;
   logic       got_ok;
   int         got_count;

   initial begin
      line_out = 1'b1;
      got_count = 0;
   end

   // flip_par corrupts the parity bit on purpose
   task automatic send_char(input logic [7:0] d, input logic flip_par);
      logic [10:0] bits;
      bits = {1'b1, (^d) ^ flip_par, d, 1'b0};
      while (tx_drive !== 1'b0) @(posedge hclk);
      for (int i = 0; i < 11; i++) begin
         line_out <= bits[i];
         repeat (DIV) @(posedge hclk);
      end
   endtask

   // samples mid-bit, well away from the port's own edges
   always begin
      @(posedge tx_drive);
      repeat (DIV / 2) @(posedge hclk);
      got_ok = (tx_line === 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge hclk);
         got_byte[i] = tx_line;
      end
      repeat (DIV) @(posedge hclk);
      got_ok = got_ok && (tx_line === ^got_byte);
      repeat (DIV) @(posedge hclk);
      got_ok = got_ok && (tx_line === 1'b1);
      got_count++;
   end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the serial slave port
// assumes the port sits alone on the bus, so hready follows hreadyout
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rsp_pkg::*;
   localparam int DIV = CLK_HZ / 38400;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_line, tx_line, tx_drive;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          bad_count = 0;
   int          total_checks = 0;

   rsp_port #(.CYC_PER_MS(50)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rx_line(rx_line), .tx_line(tx_line), .tx_drive(tx_drive));
   rsp_master #(.DIV(DIV)) u_master (.hclk(hclk), .line_out(rx_line), .tx_line(tx_line), .tx_drive(tx_drive));
   assign hready = hreadyout;

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check(v, exp, what);
   endtask

   task automatic test_regs();
      logic [31:0] v;
      rd_chk(ADDR_CTRL, 32'h0601, "ctrl reset");
      rd_chk(ADDR_DELAY, 32'h5, "delay reset");
      for (int k = 0; k < 6; k++) begin
         v = 32'((k % 4) << 12 | k << 9 | (k % 2) << 8 | 250);
         wr(ADDR_CTRL, v);
         rd_chk(ADDR_CTRL, v, "rate frame proto");
      end
      wr(ADDR_CTRL, 32'h2afa);
      wr(ADDR_CTRL, 32'h2a00);
      wr(ADDR_CTRL, 32'h2afb);
      wr(ADDR_CTRL, 32'h2cfa);
      wr(ADDR_CTRL, 32'h2efa);
      rd_chk(ADDR_CTRL, 32'h2afa, "bad id or rate kept out");
      wr(ADDR_DELAY, 32'h1);
      wr(ADDR_DELAY, 32'h64);
      wr(ADDR_DELAY, 32'h65);
      rd_chk(ADDR_DELAY, 32'h64, "delay bounds");
      wr(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0, "unmapped");
      rd_chk(ADDR_RXDATA, 32'h0, "empty fifo");
      wr(ADDR_TXDATA, 32'h3c);
      rd_chk(ADDR_STATUS, 32'h2, "tx loaded, not armed");
      repeat (300) @(posedge hclk);
      check({31'h0, tx_drive}, 32'h0, "no unsolicited drive");
      $display("test_regs done");
   endtask

   task automatic test_reply();
      int i;
      u_master.send_char(8'ha5, 1'b0);
      rd_chk(ADDR_STATUS, 32'h0107, "char held, reply waits");
      rd_chk(ADDR_RXDATA, 32'ha5, "rx byte");
      rd_chk(ADDR_STATUS, 32'h0006, "fifo drained");
      // delay is 100 ms of 50 cycles, counted from the stop-bit middle; about 1300 cycles have gone by here
      repeat (3550) @(posedge hclk);
      check({31'h0, tx_drive}, 32'h0, "reply held for delay");
      for (i = 0; i < 40000 && u_master.got_count == 0; i++) @(posedge hclk);
      check({24'h0, u_master.got_byte}, 32'h3c, "reply byte");
      check({31'h0, u_master.got_ok}, 32'h1, "reply framing");
      repeat (DIV) @(posedge hclk);
      rd_chk(ADDR_STATUS, 32'h0, "reply over, line released");
      $display("test_reply done");
   endtask

   task automatic test_parity();
      logic [31:0] v;
      wr(ADDR_CTRL, 32'h2bfa);
      u_master.send_char(8'hda, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0, v);
      check(v & 32'h10, 32'h10, "parity error flagged");
      check(v & 32'h80, 32'h80, "ascii code error flagged");
      wr(ADDR_STATUS, 32'h90);
      bus(1'b0, ADDR_STATUS, 32'h0, v);
      check(v & 32'h10, 32'h0, "parity error cleared");
      check(v & 32'h80, 32'h0, "code error cleared");
      $display("test_parity done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge hclk);
      bad_count++;
      $display("BAD %0t run did not finish", $time);
      print_verdict();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_regs();
      test_reply();
      test_parity();
      print_verdict();
   end
endmodule
